// ===== dv/bcd_unit_sva.sv
// port assertions for the decimal adjust and decrement unit
`timescale 1ns/1ps
`include "bcd_adjust_consts.vh"
module bcd_unit_sva (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // state
  input wire irq_service_o,
  input wire busy_o
);
  // ****
  // properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // a command only counts when it lands while idle
  sequence s_cmd;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && !busy_o
      && wb_adr_i == `ADDR_COMMAND;
  endsequence
  sequence s_short;
    busy_o [*4] ##1 !busy_o;
  endsequence
  sequence s_long;
    busy_o [*8] ##1 !busy_o;
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  property p_dat_upper;
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0;
  endproperty
  property p_cmd_read;
    wb_ack_o && !wb_we_i && wb_adr_i == `ADDR_COMMAND |-> wb_dat_o == 32'h0;
  endproperty
  property p_busy_short;
    s_cmd ##0 wb_dat_i[1:0] != `CMD_WORD_STEP_DOWN |=> s_short;
  endproperty
  property p_busy_long;
    s_cmd ##0 wb_dat_i[1:0] == `CMD_WORD_STEP_DOWN |=> s_long;
  endproperty
  property p_off_service;
    s_cmd ##0 wb_dat_i[1:0] == `CMD_INTERRUPT_GLOBAL_OFF |-> ##3 !irq_service_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_dat_upper: assert property (p_dat_upper) else $error("upper read bits set");
  a_cmd_read: assert property (p_cmd_read) else $error("command reads nonzero");
  a_busy_short: assert property (p_busy_short) else $error("busy not 4 cycles");
  a_busy_long: assert property (p_busy_long) else $error("busy not 8 cycles");
  a_off_service: assert property (p_off_service) else $error("service kept");
endmodule
bind bcd_adjust_decrement_unit bcd_unit_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_service_o(irq_service_o),
  .busy_o(busy_o)
);

// ===== dv/tb.sv
// self-checking bench for the decimal adjust and decrement unit
`timescale 1ns/1ps
`include "bcd_adjust_consts.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb;
  reg clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, irq_taken_i = 0;
  reg [4:0] wb_adr_i = 0;
  reg [3:0] wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 0;
  reg [7:0] irq_req_i = 0, q;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq_service_o, busy_o;
  wire [2:0] irq_index_o;
  int err_total = 0, n_checks = 0, i;
  bcd_adjust_decrement_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_req_i(irq_req_i),
    .irq_taken_i(irq_taken_i), .irq_service_o(irq_service_o), .irq_index_o(irq_index_o),
    .busy_o(busy_o));
  initial forever #50 clk_i = ~clk_i;
  // ****
  // bus tasks
  // ****
  task automatic wb(input [4:0] a, input [7:0] d, input w, output [7:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // operands, flags, command, then a write while busy that must be dropped
  task automatic op(input [7:0] hi, lo, fl, input [1:0] c, input [7:0] eh, el, ef);
    wb(`ADDR_OPERAND_HI, hi, 1, q);
    wb(`ADDR_OPERAND_LO, lo, 1, q);
    wb(`ADDR_FLAGS, fl, 1, q);
    wb(`ADDR_COMMAND, {6'h0, c}, 1, q);
    wb(`ADDR_OPERAND_HI, 8'h55, 1, q);
    while (busy_o !== 1'b0) @(posedge clk_i);
    wb(`ADDR_OPERAND_HI, 0, 0, q);
    `CHK(q, eh)
    wb(`ADDR_OPERAND_LO, 0, 0, q);
    `CHK(q, el)
    wb(`ADDR_FLAGS, 0, 0, q);
    `CHK(q, ef)
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    report_and_stop;
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 8; i++) begin
      wb({i[2:0], 2'b00}, 0, 0, q);
      `CHK(q, 8'h00)
    end
    wb(5'h02, 8'hFF, 1, q);
    wb(5'h02, 0, 0, q);
    `CHK(q, 8'h00)
    wb_sel_i <= 4'hE;
    wb(`ADDR_MASK, 8'hFF, 1, q);
    wb_sel_i <= 4'hF;
    wb(`ADDR_MASK, 0, 0, q);
    `CHK(q, 8'h00)
    op(8'h3C, 8'h00, 8'h10, `CMD_DECIMAL_ADJUST, 8'h42, 8'h00, 8'h10);
    op(8'h9A, 8'h00, 8'h00, `CMD_DECIMAL_ADJUST, 8'h00, 8'h00, 8'hC0);
    op(8'h15, 8'h00, 8'h80, `CMD_DECIMAL_ADJUST, 8'h75, 8'h00, 8'h80);
    op(8'h42, 8'h00, 8'h04, `CMD_DECIMAL_ADJUST, 8'h48, 8'h00, 8'h04);
    op(8'h8F, 8'h00, 8'h00, `CMD_DECIMAL_ADJUST, 8'h95, 8'h00, 8'h20);
    op(8'h2F, 8'h00, 8'h0C, `CMD_DECIMAL_ADJUST, 8'h29, 8'h00, 8'h0C);
    op(8'h85, 8'h00, 8'h88, `CMD_DECIMAL_ADJUST, 8'h25, 8'h00, 8'h88);
    op(8'h9F, 8'h00, 8'h8C, `CMD_DECIMAL_ADJUST, 8'h39, 8'h00, 8'h8C);
    op(8'h45, 8'h00, 8'h08, `CMD_DECIMAL_ADJUST, 8'h45, 8'h00, 8'h08);
    op(8'h00, 8'h00, 8'h8C, `CMD_BYTE_STEP_DOWN, 8'hFF, 8'h00, 8'hAC);
    op(8'h01, 8'h00, 8'h00, `CMD_BYTE_STEP_DOWN, 8'h00, 8'h00, 8'h40);
    op(8'h10, 8'h77, 8'h00, `CMD_BYTE_STEP_DOWN, 8'h0F, 8'h77, 8'h00);
    op(8'h00, 8'h00, 8'h8C, `CMD_WORD_STEP_DOWN, 8'hFF, 8'hFF, 8'hAC);
    op(8'h80, 8'h00, 8'h00, `CMD_WORD_STEP_DOWN, 8'h7F, 8'hFF, 8'h10);
    op(8'h01, 8'h00, 8'h00, `CMD_WORD_STEP_DOWN, 8'h00, 8'hFF, 8'h00);
    op(8'h00, 8'h01, 8'h00, `CMD_WORD_STEP_DOWN, 8'h00, 8'h00, 8'h40);
    wb(`ADDR_MASK, 8'hFF, 1, q);
    irq_req_i <= 8'h05;
    repeat (6) @(posedge clk_i);
    wb(`ADDR_PENDING, 0, 0, q);
    `CHK(q, 8'h05)
    `CHK(irq_service_o, 1'b0)
    wb(`ADDR_MODE, 8'h01, 1, q);
    repeat (2) @(posedge clk_i);
    `CHK(irq_service_o, 1'b1)
    `CHK(irq_index_o, 3'h0)
    op(8'h12, 8'h34, 8'hFC, `CMD_INTERRUPT_GLOBAL_OFF, 8'h12, 8'h34, 8'hFC);
    wb(`ADDR_MODE, 0, 0, q);
    `CHK(q, 8'h00)
    `CHK(irq_service_o, 1'b0)
    wb(`ADDR_MODE, 8'h01, 1, q);
    irq_taken_i <= 1'b1;
    @(posedge clk_i);
    irq_taken_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(irq_index_o, 3'h2)
    wb(`ADDR_STATUS, 0, 0, q);
    `CHK(q, 8'h06)
    report_and_stop;
  end
endmodule

// ===== hdl/bcd_adjust_consts.vh
// constants for the decimal adjust and decrement unit
`ifndef BCD_ADJUST_CONSTS_VH
`define BCD_ADJUST_CONSTS_VH

// ********************************
// register byte addresses
// ********************************
`define ADDR_OPERAND_HI 5'h00
`define ADDR_OPERAND_LO 5'h04
`define ADDR_FLAGS 5'h08
`define ADDR_COMMAND 5'h0C
`define ADDR_MODE 5'h10
`define ADDR_MASK 5'h14
`define ADDR_PENDING 5'h18
`define ADDR_STATUS 5'h1C

// ********************************
// flag register bit positions
// ********************************
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4
`define FLAG_D 3
`define FLAG_H 2

// ********************************
// command codes
// ********************************
`define CMD_DECIMAL_ADJUST 2'h0
`define CMD_BYTE_STEP_DOWN 2'h1
`define CMD_WORD_STEP_DOWN 2'h2
`define CMD_INTERRUPT_GLOBAL_OFF 2'h3

// ********************************
// reset values
// ********************************
`define RST_OPERAND 8'h00
`define RST_FLAGS 8'h00
`define RST_MODE 8'h00
`define RST_MASK 8'h00
`define RST_PENDING 8'h00

// ********************************
// mode register, timing and bcd limits
// ********************************
`define MODE_GLOBAL_EN 0
`define CYCLES_SHORT 4'h4
`define CYCLES_LONG 4'h8
`define BCD_NINE 4'h9
`define BCD_MAX_BYTE 8'h99

`endif

// ===== hdl/bcd_adjust_decrement_unit.v
// decimal adjust, byte and word decrement, global interrupt off
`timescale 1ns/1ps
`include "bcd_adjust_consts.vh"
module bcd_adjust_decrement_unit (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // interrupt requests and service
  input wire [7:0] irq_req_i,
  input wire irq_taken_i,
  output reg irq_service_o,
  output reg [2:0] irq_index_o,
  // execution state
  output wire busy_o
);
  // ********************************
  // state
  // ********************************
  localparam ST_IDLE = 2'b01;
  localparam ST_EXEC = 2'b10;

  reg [1:0] state_q;
  reg [3:0] wait_q;
  reg [7:0] operand_hi_q;
  reg [7:0] operand_lo_q;
  reg [7:0] flags_q;
  reg [7:0] mode_q;
  reg [7:0] mask_q;
  reg [7:0] pending_q;
  reg [1:0] last_cmd_q;
  reg [7:0] op_count_q;
  reg [7:0] irq_meta_q;
  reg [7:0] irq_sync_q;
  reg [7:0] irq_prev_q;

  reg [7:0] pending_d;
  reg [2:0] index_d;
  reg service_d;
  reg [7:0] exec_hi_d;
  reg [7:0] exec_lo_d;
  reg [7:0] exec_flags_d;
  reg [7:0] exec_mode_d;
  reg [31:0] read_d;
  integer k;

  wire req = wb_cyc_i & wb_stb_i;
  wire bus_write = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire cmd_write = bus_write & (wb_adr_i == `ADDR_COMMAND) & (state_q == ST_IDLE);
  wire [1:0] cmd = wb_dat_i[1:0];
  wire [7:0] irq_rise = irq_sync_q & ~irq_prev_q;

  assign busy_o = (state_q == ST_EXEC);

  // ********************************
  // datapath
  // ********************************
  wire [7:0] da_result;
  wire da_carry;
  wire [7:0] dec8_result;
  wire dec8_zero;
  wire dec8_sign;
  wire dec8_ovf;
  wire [15:0] dec16_result;
  wire dec16_zero;
  wire dec16_sign;
  wire dec16_ovf;

  // the d flag records whether the previous arithmetic was a subtraction
  decimal_adjust_calc u_adjust (
    .value_i(operand_hi_q),
    .carry_i(flags_q[`FLAG_C]),
    .half_i(flags_q[`FLAG_H]),
    .subtract_i(flags_q[`FLAG_D]),
    .result_o(da_result),
    .carry_o(da_carry)
  );

  step_down_calc #(.WIDTH(8)) u_byte_dec (
    .value_i(operand_hi_q),
    .result_o(dec8_result),
    .zero_o(dec8_zero),
    .sign_o(dec8_sign),
    .overflow_o(dec8_ovf)
  );

  // upper byte sits at the lower address
  step_down_calc #(.WIDTH(16)) u_word_dec (
    .value_i({operand_hi_q, operand_lo_q}),
    .result_o(dec16_result),
    .zero_o(dec16_zero),
    .sign_o(dec16_sign),
    .overflow_o(dec16_ovf)
  );

  // ********************************
  // instruction results
  // ********************************
  // each command starts from the current registers, so flags that a
  // command leaves alone simply carry over
  always @* begin
    exec_hi_d = operand_hi_q;
    exec_lo_d = operand_lo_q;
    exec_flags_d = flags_q;
    exec_mode_d = mode_q;
    case (cmd)
      `CMD_DECIMAL_ADJUST: begin
        exec_hi_d = da_result;
        exec_flags_d[`FLAG_C] = da_carry;
        exec_flags_d[`FLAG_Z] = (da_result == 8'h00);
        exec_flags_d[`FLAG_S] = da_result[7];
      end
      `CMD_BYTE_STEP_DOWN: begin
        exec_hi_d = dec8_result;
        exec_flags_d[`FLAG_Z] = dec8_zero;
        exec_flags_d[`FLAG_S] = dec8_sign;
        exec_flags_d[`FLAG_V] = dec8_ovf;
      end
      `CMD_WORD_STEP_DOWN: begin
        exec_hi_d = dec16_result[15:8];
        exec_lo_d = dec16_result[7:0];
        exec_flags_d[`FLAG_Z] = dec16_zero;
        exec_flags_d[`FLAG_S] = dec16_sign;
        exec_flags_d[`FLAG_V] = dec16_ovf;
      end
      `CMD_INTERRUPT_GLOBAL_OFF: begin
        // condition flags stay as they are
        exec_mode_d[`MODE_GLOBAL_EN] = 1'b0;
      end
      default: begin
        exec_mode_d = mode_q;
      end
    endcase
  end

  // ********************************
  // execution and registers
  // ********************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      wait_q <= 4'h0;
      operand_hi_q <= `RST_OPERAND;
      operand_lo_q <= `RST_OPERAND;
      flags_q <= `RST_FLAGS;
      mode_q <= `RST_MODE;
      mask_q <= `RST_MASK;
      last_cmd_q <= `CMD_DECIMAL_ADJUST;
      op_count_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (bus_write) begin
            case (wb_adr_i)
              `ADDR_OPERAND_HI: operand_hi_q <= wb_dat_i[7:0];
              `ADDR_OPERAND_LO: operand_lo_q <= wb_dat_i[7:0];
              `ADDR_FLAGS: flags_q <= wb_dat_i[7:0];
              `ADDR_MODE: mode_q <= wb_dat_i[7:0];
              `ADDR_MASK: mask_q <= wb_dat_i[7:0];
              default: mode_q <= mode_q;
            endcase
          end
          if (cmd_write) begin
            state_q <= ST_EXEC;
            last_cmd_q <= cmd;
            op_count_q <= op_count_q + 8'h01;
            // the word step takes twice the cycles of the others
            wait_q <= (cmd == `CMD_WORD_STEP_DOWN) ? `CYCLES_LONG - 4'h1
                                                   : `CYCLES_SHORT - 4'h1;
            operand_hi_q <= exec_hi_d;
            operand_lo_q <= exec_lo_d;
            flags_q <= exec_flags_d;
            mode_q <= exec_mode_d;
          end
        end
        ST_EXEC: begin
          // operand, flag, mode and mask writes are dropped while an instruction runs
          if (wait_q == 4'h0) begin
            state_q <= ST_IDLE;
          end else begin
            wait_q <= wait_q - 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ********************************
  // interrupt pending and service
  // ********************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_meta_q <= 8'h00;
      irq_sync_q <= 8'h00;
      irq_prev_q <= 8'h00;
    end else begin
      irq_meta_q <= irq_req_i;
      irq_sync_q <= irq_meta_q;
      irq_prev_q <= irq_sync_q;
    end
  end

  always @* begin
    pending_d = pending_q;
    if (bus_write && (wb_adr_i == `ADDR_PENDING)) begin
      pending_d = pending_d & ~wb_dat_i[7:0];
    end
    // a taken pulse only counts while service is offered
    if (irq_taken_i && irq_service_o) begin
      pending_d[irq_index_o] = 1'b0;
    end
    // a new request wins over a clear in the same cycle
    pending_d = pending_d | irq_rise;
  end

  // lowest numbered pending bit wins the service slot
  always @* begin
    index_d = 3'h0;
    service_d = 1'b0;
    for (k = 7; k >= 0; k = k - 1) begin
      if (pending_q[k] && mask_q[k]) begin
        index_d = k[2:0];
        service_d = 1'b1;
      end
    end
    // pending bits still collect while servicing is off
    service_d = service_d & mode_q[`MODE_GLOBAL_EN];
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pending_q <= `RST_PENDING;
      irq_service_o <= 1'b0;
      irq_index_o <= 3'h0;
    end else begin
      pending_q <= pending_d;
      irq_service_o <= service_d & ~(irq_taken_i & irq_service_o);
      irq_index_o <= index_d;
    end
  end

  // ********************************
  // register read mux
  // ********************************
  // command register is write only and reads as zero
  always @* begin
    case (wb_adr_i)
      `ADDR_OPERAND_HI: read_d = {24'h000000, operand_hi_q};
      `ADDR_OPERAND_LO: read_d = {24'h000000, operand_lo_q};
      `ADDR_FLAGS: read_d = {24'h000000, flags_q};
      `ADDR_MODE: read_d = {24'h000000, mode_q};
      `ADDR_MASK: read_d = {24'h000000, mask_q};
      `ADDR_PENDING: read_d = {24'h000000, pending_q};
      // count in 15:8, last command in 2:1, busy in 0
      `ADDR_STATUS: read_d = {16'h0000, op_count_q, 5'h00, last_cmd_q, busy_o};
      default: read_d = 32'h00000000;
    endcase
  end

  // ********************************
  // wishbone answer
  // ********************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= read_d;
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end
endmodule

// ===== hdl/decimal_adjust_calc.v
// bcd correction of a byte after addition or subtraction
`timescale 1ns/1ps
`include "bcd_adjust_consts.vh"
module decimal_adjust_calc (
  // operand and incoming flags
  input wire [7:0] value_i,
  input wire carry_i,
  input wire half_i,
  input wire subtract_i,
  // result
  output reg [7:0] result_o,
  output reg carry_o
);
  reg low_fix;
  reg high_fix;
  reg [7:0] addend;

  always @* begin
    low_fix = 1'b0;
    high_fix = 1'b0;
    addend = 8'h00;
    carry_o = carry_i;
    if (!subtract_i) begin
      low_fix = half_i | (value_i[3:0] > `BCD_NINE);
      // above 99 the high digit overflows once the low fix is applied
      high_fix = carry_i | (value_i > `BCD_MAX_BYTE);
      addend = {1'b0, high_fix, high_fix, 1'b0, 1'b0, low_fix, low_fix, 1'b0};
      carry_o = high_fix;
    end else begin
      case ({carry_i, half_i})
        2'b01: addend = 8'hFA;
        2'b10: addend = 8'hA0;
        2'b11: addend = 8'h9A;
        default: addend = 8'h00;
      endcase
    end
    result_o = value_i + addend;
  end
endmodule

// ===== hdl/step_down_calc.v
// decrement by one with zero, sign and overflow results
`timescale 1ns/1ps
module step_down_calc #(
  parameter WIDTH = 8
) (
  // operand
  input wire [WIDTH-1:0] value_i,
  // result and flags
  output wire [WIDTH-1:0] result_o,
  output wire zero_o,
  output wire sign_o,
  output wire overflow_o
);
  // zero wraps naturally: zero in gives all ones out
  assign result_o = value_i - {{(WIDTH-1){1'b0}}, 1'b1};
  assign zero_o = (result_o == {WIDTH{1'b0}});
  assign sign_o = result_o[WIDTH-1];
  // only the most negative value can overflow downward
  assign overflow_o = value_i[WIDTH-1] & ~result_o[WIDTH-1];
endmodule
